/* shared/iofl_pkg.sv */
// constants, field layouts and carrier types for the operand and flag block
// assumes a single mclk domain and an apb master with 32-bit data
// How it works
// - byte memory, sixteen-bit addresses
// - bit 0 least, bit 7 most significant
// - instructions one to three bytes long
// - multi-byte data stored low byte first
// - direct address: byte 2 low, byte 3 high
// - register mode reads register, memory only for code 110
// - indirect address: pair first register high
// - immediate 8 or 16 bits, low first
// - program counter advances to higher addresses
// - direct branch: byte 2 low, byte 3 high
// - indirect branch: pair first register high
// - restart jumps to eight times field
// - five one-bit flags, set 1, reset 0
// - zero flag set when result zero
// - sign flag copies result top bit
// - parity flag set on even ones
// - carry flag on carry or borrow
// - half carry from bit 3 into 4
// - field 111 accumulator, 000 b, 001 c
// - io port number is eight bits
// - pair field: bc, de, hl, stack pointer
package iofl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_INSTR   = 8'h00;
  localparam logic [7:0] OFS_SP      = 8'h10;
  localparam logic [7:0] OFS_PC      = 8'h18;
  localparam logic [7:0] OFS_CTRL    = 8'h1c;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_EA      = 8'h24;
  localparam logic [7:0] OFS_OPND    = 8'h28;
  localparam logic [7:0] OFS_MEMDATA = 8'h2c;
  localparam logic [7:0] OFS_IOPORT  = 8'h30;
  localparam logic [7:0] OFS_GPR     = 8'h40;
  localparam logic [7:0] OFS_GPR_END = 8'h5c;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OP_LSB   = 4;
  localparam int CTRL_ALU_EN   = 8;
  localparam int CTRL_GO       = 9;
  // status fields
  localparam int ST_CY  = 0;
  localparam int ST_P   = 2;
  localparam int ST_AC  = 4;
  localparam int ST_Z   = 6;
  localparam int ST_S   = 7;
  localparam int ST_MEM = 8;
  // register field codes
  localparam logic [2:0] RF_B   = 3'h0;
  localparam logic [2:0] RF_C   = 3'h1;
  localparam logic [2:0] RF_D   = 3'h2;
  localparam logic [2:0] RF_E   = 3'h3;
  localparam logic [2:0] RF_H   = 3'h4;
  localparam logic [2:0] RF_L   = 3'h5;
  localparam logic [2:0] RF_MEM = 3'h6;
  localparam logic [2:0] RF_ACC = 3'h7;
  // register pair codes
  localparam logic [1:0] RP_BC = 2'h0;
  localparam logic [1:0] RP_DE = 2'h1;
  localparam logic [1:0] RP_HL = 2'h2;
  localparam logic [1:0] RP_SP = 2'h3;
  // reset values and restart scale
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [7:0]  RESTART_SCALE = 8'h08;
  typedef enum logic [3:0] {
    MODE_SEQ     = 4'h0,
    MODE_DIRECT  = 4'h1,
    MODE_REG     = 4'h2,
    MODE_REG_IND = 4'h3,
    MODE_IMM8    = 4'h4,
    MODE_IMM16   = 4'h5,
    MODE_BR_DIR  = 4'h6,
    MODE_BR_IND  = 4'h7,
    MODE_RESTART = 4'h8,
    MODE_IO      = 4'h9
  } iofl_mode_e;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADC = 4'h1,
    OP_SUB = 4'h2,
    OP_SBB = 4'h3,
    OP_CMP = 4'h4,
    OP_AND = 4'h5,
    OP_OR  = 4'h6,
    OP_XOR = 4'h7,
    OP_INC = 4'h8,
    OP_DEC = 4'h9
  } iofl_op_e;
  typedef struct packed {
    logic s;
    logic z;
    logic ac;
    logic p;
    logic cy;
  } iofl_flags_s;
  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
  } iofl_instr_s;
endpackage

/* logic/iofl_core.sv */
// operand addressing, branch target and condition flag logic behind an apb slave
// assumes an apb master on mclk; memory bytes are supplied through a register
`timescale 1ns/10ps
module iofl_core
  import iofl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // decoded results
  output logic [15:0]      mem_addr,
  output logic             mem_access,
  output logic [15:0]      prog_counter,
  output logic [7:0]       io_port
);

  logic [7:0]   gpr_q [0:7];
  logic [15:0]  sp_q;
  logic [15:0]  pc_q;
  logic [15:0]  ea_q;
  logic [15:0]  opnd_q;
  logic [7:0]   memdata_q;
  logic [7:0]   io_port_q;
  logic         mem_acc_q;
  iofl_instr_s  instr_q;
  iofl_flags_s  flags_q;
  iofl_flags_s  flags_d;
  iofl_mode_e   mode_q;
  iofl_op_e     op_q;
  logic         alu_en_q;
  logic         exec_q;
  logic         pready_q;
  logic         pslverr_q;
  logic [31:0]  prdata_q;
  logic         wr_now;
  logic         hit;
  logic [31:0]  rd_val;
  logic [7:0]   src8;
  logic [15:0]  pair16;
  logic [9:0]   alu_out;
  logic [7:0]   alu_b;

  function automatic logic [15:0] pair_val(input logic [1:0] sel);
    logic [15:0] v;
    v = sp_q;
    case (sel)
      RP_BC:   v = {gpr_q[RF_B], gpr_q[RF_C]};
      RP_DE:   v = {gpr_q[RF_D], gpr_q[RF_E]};
      RP_HL:   v = {gpr_q[RF_H], gpr_q[RF_L]};
      default: v = sp_q;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] reg_val(input logic [2:0] f);
    logic [7:0] v;
    v = gpr_q[f];
    if (f == RF_MEM) begin
      v = memdata_q;
    end
    return v;
  endfunction

  // general register window
  function automatic logic is_gpr(input logic [7:0] a);
    logic g;
    g = (a >= OFS_GPR) && (a <= OFS_GPR_END);
    return g;
  endfunction

  // write strobe for one register offset
  function automatic logic wr_to(input logic [7:0] ofs);
    logic w;
    w = wr_now && (paddr == ofs);
    return w;
  endfunction

  // refuses unmapped and misaligned offsets
  function automatic logic valid_addr(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    case (a)
      OFS_INSTR, OFS_SP, OFS_PC, OFS_CTRL, OFS_STATUS: ok = 1'b1;
      OFS_EA, OFS_OPND, OFS_MEMDATA, OFS_IOPORT:       ok = 1'b1;
      default: begin
        // general registers, aligned words only
        ok = (a[1:0] == 2'h0) && is_gpr(a);
      end
    endcase
    return ok;
  endfunction

  // result {cy, ac, value}
  function automatic logic [9:0] alu(input iofl_op_e op, input logic [7:0] a,
                                     input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = 9'h000;
    h = 5'h00;
    case (op)
      OP_ADD, OP_ADC: begin
        s = 9'(a) + 9'(b) + 9'(op == OP_ADC ? ci : 1'b0);
        h = 5'(a[3:0]) + 5'(b[3:0]) + 5'(op == OP_ADC ? ci : 1'b0);
      end
      OP_SUB, OP_SBB, OP_CMP: begin
        s = 9'(a) - 9'(b) - 9'(op == OP_SBB ? ci : 1'b0);
        // half carry of a + ~b + 1 (a + ~b + ~ci for sbb), no borrow out of bit 3
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} +
            {4'h0, ((op == OP_SBB) ? ~ci : 1'b1)};
      end
      // logic ops leave carry and half carry clear
      OP_AND:  s = {1'b0, a & b};
      OP_OR:   s = {1'b0, a | b};
      OP_XOR:  s = {1'b0, a ^ b};
      OP_INC: begin
        s = 9'(a) + 9'h001;
        h = 5'(a[3:0]) + 5'h01;
      end
      OP_DEC: begin
        s = 9'(a) - 9'h001;
        h = 5'(a[3:0]) + 5'h0f;
      end
      default: s = {1'b0, a};
    endcase
    return {s[8], h[4], s[7:0]};
  endfunction

  // apb strobes
  // refused writes leave every register unchanged
  assign wr_now = psel & penable & pready_q & pwrite & hit;
  assign hit    = valid_addr(paddr);

  // no wait state, ready in the first access cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable & ~pready_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pslverr_q <= 1'b0;
    end else begin
      // refusal flag rises with ready
      pslverr_q <= psel & ~penable & ~pready_q & ~hit;
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_gpr(paddr)) begin
      rd_val = {24'h00_0000, gpr_q[paddr[4:2]]};
    end else begin
      case (paddr)
        OFS_INSTR:   rd_val = {8'h00, instr_q};
        OFS_SP:      rd_val = {16'h0000, sp_q};
        OFS_PC:      rd_val = {16'h0000, pc_q};
        OFS_CTRL:    rd_val = {23'h00_0000, alu_en_q, op_q, mode_q};
        OFS_STATUS: begin
          rd_val[ST_CY]  = flags_q.cy;
          rd_val[ST_P]   = flags_q.p;
          rd_val[ST_AC]  = flags_q.ac;
          rd_val[ST_Z]   = flags_q.z;
          rd_val[ST_S]   = flags_q.s;
          rd_val[ST_MEM] = mem_acc_q;
        end
        OFS_EA:      rd_val = {16'h0000, ea_q};
        OFS_OPND:    rd_val = {16'h0000, opnd_q};
        OFS_MEMDATA: rd_val = {24'h00_0000, memdata_q};
        OFS_IOPORT:  rd_val = {24'h00_0000, io_port_q};
        default:     rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pready_q) begin
      // refused reads return zero
      prdata_q <= hit ? rd_val : 32'h0000_0000;
    end
  end

  // instruction bytes, memory byte, control
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      instr_q   <= '0;
      memdata_q <= 8'h00;
      mode_q    <= MODE_SEQ;
      op_q      <= OP_ADD;
      alu_en_q  <= 1'b0;
    end else if (wr_now) begin
      case (paddr)
        OFS_INSTR:   instr_q   <= pwdata[23:0];
        OFS_MEMDATA: memdata_q <= pwdata[7:0];
        OFS_CTRL: begin
          mode_q   <= iofl_mode_e'(pwdata[CTRL_MODE_LSB +: 4]);
          op_q     <= iofl_op_e'(pwdata[CTRL_OP_LSB +: 4]);
          alu_en_q <= pwdata[CTRL_ALU_EN];
        end
        default: ;
      endcase
    end
  end

  // go bit starts one execute cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= wr_to(OFS_CTRL) & pwdata[CTRL_GO];
    end
  end

  // operand fetch, follows register file reads inside the functions
  always_comb begin
    src8   = reg_val(instr_q.b1[2:0]);
    pair16 = pair_val(instr_q.b1[5:4]);
    alu_b  = (mode_q == MODE_IMM8) ? instr_q.b2 : src8;
  end
  assign alu_out = alu(op_q, gpr_q[RF_ACC], alu_b, flags_q.cy);

  // general registers, accumulator result
  // execute and bus write never share an edge
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        gpr_q[i] <= 8'h00;
      end
    end else if (exec_q && alu_en_q && op_q != OP_CMP) begin
      gpr_q[RF_ACC] <= alu_out[7:0];
    end else if (wr_now && is_gpr(paddr)) begin
      gpr_q[paddr[4:2]] <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sp_q <= SP_RST;
    end else if (wr_to(OFS_SP)) begin
      sp_q <= pwdata[15:0];
    end
  end

  // flag update
  always_comb begin
    flags_d = flags_q;
    flags_d.z  = (alu_out[7:0] == 8'h00);
    flags_d.s  = alu_out[7];
    flags_d.p  = ~^alu_out[7:0];
    flags_d.ac = alu_out[8];
    if (op_q != OP_INC && op_q != OP_DEC) begin
      flags_d.cy = alu_out[9];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flags_q <= '0;
    end else if (exec_q && alu_en_q) begin
      // execute never meets a status write
      flags_q <= flags_d;
    end else if (wr_to(OFS_STATUS)) begin
      flags_q.cy <= pwdata[ST_CY];
      flags_q.p  <= pwdata[ST_P];
      flags_q.ac <= pwdata[ST_AC];
      flags_q.z  <= pwdata[ST_Z];
      flags_q.s  <= pwdata[ST_S];
    end
  end

  // effective address and operand
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ea_q      <= 16'h0000;
      opnd_q    <= 16'h0000;
      mem_acc_q <= 1'b0;
      io_port_q <= 8'h00;
    end else if (exec_q) begin
      case (mode_q)
        MODE_DIRECT: begin
          // byte 3 high, byte 2 low
          ea_q      <= {instr_q.b3, instr_q.b2};
          mem_acc_q <= 1'b1;
        end
        MODE_REG: begin
          // register operand, memory only for code 110
          // hl addresses the memory operand
          opnd_q    <= {8'h00, src8};
          mem_acc_q <= (instr_q.b1[2:0] == RF_MEM);
          ea_q      <= pair_val(RP_HL);
        end
        MODE_REG_IND: begin
          ea_q      <= pair16;
          mem_acc_q <= 1'b1;
        end
        MODE_IMM8: begin
          opnd_q    <= {8'h00, instr_q.b2};
          mem_acc_q <= 1'b0;
        end
        MODE_IMM16: begin
          opnd_q    <= {instr_q.b3, instr_q.b2};
          mem_acc_q <= 1'b0;
        end
        MODE_IO: begin
          io_port_q <= instr_q.b2;
          mem_acc_q <= 1'b0;
        end
        default: mem_acc_q <= 1'b0;
      endcase
    end
  end

  // program counter
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pc_q <= PC_RST;
    end else if (exec_q) begin
      case (mode_q)
        MODE_BR_DIR:  pc_q <= {instr_q.b3, instr_q.b2};
        MODE_BR_IND:  pc_q <= pair16;
        MODE_RESTART: pc_q <= 16'(instr_q.b1[5:3]) * 16'(RESTART_SCALE);
        MODE_DIRECT, MODE_IMM16: pc_q <= pc_q + 16'h0003;
        MODE_IMM8, MODE_IO:      pc_q <= pc_q + 16'h0002;
        default:      pc_q <= pc_q + 16'h0001;
      endcase
    end else if (wr_to(OFS_PC)) begin
      pc_q <= pwdata[15:0];
    end
  end

  assign mem_addr     = ea_q;
  assign mem_access   = mem_acc_q;
  assign prog_counter = pc_q;
  assign io_port      = io_port_q;
  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;

endmodule

/* verif/iofl_chk_assertions.sv */
// protocol and cause checks on the iofl_core ports
// assumes one mclk domain and a synchronous active-low reset
`timescale 1ns/10ps
module iofl_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // results
  input wire logic [15:0] mem_addr,
  input wire logic        mem_access,
  input wire logic [15:0] prog_counter,
  input wire logic [7:0]  io_port
);
  logic wr;
  assign wr = psel && penable && pwrite && pready;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_ready_one_wait: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("ready without a setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access cycle");
  a_err_misalign: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_reset_clears: assert property (disable iff (1'b0) !nrst |=>
    prog_counter == 16'h0 && io_port == 8'h0 && !mem_access && !pready)
    else $error("outputs not cleared by reset");
  a_pc_cause: assert property ($changed(prog_counter) |->
    $past(wr) || $past(wr, 2) || $past(!nrst))
    else $error("program counter moved without a write");
  a_port_cause: assert property ($changed(io_port) |-> $past(wr, 2) || $past(!nrst))
    else $error("port number moved without execute");
  a_ea_cause: assert property ($changed(mem_addr) |-> $past(wr, 2) || $past(!nrst))
    else $error("address moved without execute");

  c_refused: cover property (pslverr);
  c_pc_moves: cover property ($changed(prog_counter));
  c_mem_use: cover property ($rose(mem_access));
endmodule

bind iofl_core iofl_chk u_chk (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .mem_addr, .mem_access, .prog_counter, .io_port);

/* verif/iofl_mem_model.sv */
// byte memory standing behind the effective address
// assumes mem_addr and mem_access from iofl_core
`timescale 1ns/10ps
module iofl_mem_model (
  // request
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_access,
  // answer
  output logic [7:0]       rd_byte
);
  assign rd_byte = mem_access ? mem_addr[7:0] ^ mem_addr[15:8] : ~(mem_addr[7:0] ^ mem_addr[15:8]);
endmodule

/* verif/tb_top.sv */
// self-checking bench for iofl_core over apb
// assumes iofl_pkg and the iofl_mem_model partner
`timescale 1ns/10ps
module tb_top
  import iofl_pkg::*;
;
  logic        mclk = 0;
  logic        nrst = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, mem_access, c, ci, cy, ac;
  logic [31:0] prdata;
  logic [15:0] mem_addr, prog_counter, pc0, sp;
  logic [7:0]  io_port, mbyte, a, b, bb, r, g[8];
  logic [23:0] ins;
  logic [8:0]  s;
  logic [4:0]  h;
  logic [32:0] expq[$];
  int          o;
  int          fails = 0;
  int          check_count = 0;
  int          seed = 32'h10c4;

  always #20 mclk = ~mclk;

  iofl_core uut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .mem_addr, .mem_access, .prog_counter, .io_port);
  iofl_mem_model u_mem (.mem_addr, .mem_access, .rd_byte(mbyte));

  function automatic logic [15:0] pr(input int p);
    return p == 3 ? sp : {g[2*p], g[2*p+1]};
  endfunction

  task automatic finish_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    expq.push_back(e);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready === 1'b1) begin
      psel <= 0;
      penable <= 0;
    end else begin
      fails++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      finish_test;
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1, ad, d, 33'h0);
  endtask

  task automatic rdx(input logic [7:0] ad, input logic [31:0] e);
    apb(0, ad, $random(seed), {1'b0, e});
  endtask

  task automatic ex(input logic [3:0] m, input logic [3:0] op, input logic en,
                    input logic [23:0] i);
    wr(OFS_INSTR, {8'h0, i});
    wr(OFS_PC, {16'h0, pc0});
    wr(OFS_CTRL, {22'h0, 1'b1, en, op, m});
  endtask

  // takes the oldest note for every completed transfer
  always @(posedge mclk) begin
    if (psel && penable && pready && expq.size() > 0) begin
      chk("apb", {pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1;
    pc0 = 16'($random(seed));
    sp = 16'($random(seed));
    ins = 24'($random(seed));
    wr(OFS_SP, {16'h0, sp});
    for (int i = 0; i < 8; i++) begin
      g[i] = 8'($random(seed));
      wr(OFS_GPR + 8'(4 * i), {24'h0, g[i]});
    end
    for (int i = 0; i < 8; i++) rdx(OFS_GPR + 8'(4 * i), {24'h0, g[i]});
    apb(0, 8'h04, 32'h0, {1'b1, 32'h0});
    apb(1, 8'h19, 32'h5, {1'b1, 32'h0});
    rdx(OFS_PC, 32'h0);
    ex(MODE_SEQ, 4'h0, 0, ins);
    rdx(OFS_PC, {16'h0, pc0 + 16'h1});
    chk("pc_pin", {17'h0, prog_counter}, {17'h0, pc0 + 16'h1});
    ex(MODE_DIRECT, 4'h0, 0, ins);
    rdx(OFS_EA, {16'h0, ins[23:8]});
    chk("addr_pin", {17'h0, mem_addr}, {17'h0, ins[23:8]});
    rdx(OFS_PC, {16'h0, pc0 + 16'h3});
    wr(OFS_MEMDATA, {24'h0, mbyte});
    for (int k = 0; k < 8; k++) begin
      ex(MODE_REG, 4'h0, 0, {16'h0, 5'h0, 3'(k)});
      rdx(OFS_OPND, {24'h0, k == 6 ? ins[15:8] ^ ins[23:16] : g[k]});
      rdx(OFS_STATUS, {23'h0, k == 6, 8'h0});
      chk("mem_pin", {32'h0, mem_access}, {32'h0, k == 6});
    end
    for (int p = 0; p < 4; p++) begin
      ex(MODE_REG_IND, 4'h0, 0, {16'h0, 2'h0, 2'(p), 4'h0});
      rdx(OFS_EA, {16'h0, pr(p)});
      ex(MODE_BR_IND, 4'h0, 0, {16'h0, 2'h3, 2'(p), 4'h9});
      rdx(OFS_PC, {16'h0, pr(p)});
    end
    ex(MODE_IMM16, 4'h0, 0, ins);
    rdx(OFS_OPND, {16'h0, ins[23:8]});
    ex(MODE_BR_DIR, 4'h0, 0, ins);
    rdx(OFS_PC, {16'h0, ins[23:8]});
    for (int n = 0; n < 8; n++) begin
      ex(MODE_RESTART, 4'h0, 0, {16'h0, 2'h3, 3'(n), 3'h7});
      rdx(OFS_PC, {26'h0, 3'(n), 3'h0});
    end
    ex(MODE_IO, 4'h0, 0, ins);
    rdx(OFS_IOPORT, {24'h0, ins[15:8]});
    chk("port_pin", {25'h0, io_port}, {25'h0, ins[15:8]});
    rdx(OFS_PC, {16'h0, pc0 + 16'h2});
    for (int i = 0; i < 40; i++) begin
      o = i % 10;
      a = 8'($random(seed));
      b = 8'($random(seed));
      c = 1'($random(seed));
      wr(OFS_GPR + 8'h1c, {24'h0, a});
      wr(OFS_STATUS, {31'h0, c});
      ex(MODE_IMM8, 4'(o), 1, {8'h0, b, 8'h0});
      bb = b;
      ci = 0;
      case (o)
        1: ci = c;
        2, 4: begin
          bb = ~b;
          ci = 1;
        end
        3: begin
          bb = ~b;
          ci = ~c;
        end
        8: bb = 8'h1;
        9: begin
          bb = 8'hfe;
          ci = 1;
        end
        default: ;
      endcase
      s = a + bb + ci;
      h = a[3:0] + bb[3:0] + ci;
      cy = (o inside {[2:4], 9}) ? ~s[8] : s[8];
      ac = h[4];
      r = s[7:0];
      if (o inside {[5:7]}) begin
        r = (o == 5) ? a & b : (o == 6) ? a | b : a ^ b;
        cy = 0;
        ac = 0;
      end
      if (o > 7) cy = c;
      rdx(OFS_STATUS, {24'h0, r[7], r == 8'h0, 1'b0, ac, 1'b0, ~^r, 1'b0, cy});
      rdx(OFS_GPR + 8'h1c, {24'h0, o == 4 ? a : r});
    end
    repeat (3) @(posedge mclk);
    finish_test;
  end
endmodule
